// ==== verilog/sup_defines.vh ====
`ifndef SUP_DEFINES_VH
`define SUP_DEFINES_VH

// clock and internal millisecond tick
`define CLK_NS        10
`define TICK_NS       1000000
`define TICK_CYC      17'h186A0

// ownership status byte: bus i uses bits 4*i+3 .. 4*i
`define OWN_RST       8'h01
`define F_CTL         0
`define F_REQ         1
`define F_ALEN        2
`define F_ERR         3

// command codes
`define CMD_CLRF      8'h03
`define CMD_CLAIM     8'hD8
`define CMD_BUSSTAT   8'hD7

// times in milliseconds (tick counts) and the overvoltage retry limit
`define CC_HOLD_MS    16'h4E20
`define OFF_MIN_MS    16'h07D0
`define OV_RETRY_MS   16'h03E8
`define OV_WIN_MS     16'hEA60
`define SETTLE_MS     16'h000A
`define OV_MAX        2'h3

// status bits that report faults caused outside the unit
`define EXT_MASK      16'h0003

`endif

// ==== verilog/sync2.v ====
`timescale 1ns/1ps
module sync2 #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule

// ==== verilog/fault_supervisor.v ====
`timescale 1ns/1ps
`include "sup_defines.vh"

// Overview of operation
// - after reset bus zero holds control; status reads 0x01
// - ownership status returns to default only on bias loss, never by command
// - non-owner may only claim control or clear faults; other writes refused
// - claim command 0xD8 moves authority to the requesting master
// - hand-over waits until the owner's write transfer has ended with STOP
// - owner doing only reads does not delay hand-over; reads served on both
// - claim acted on only after its PEC byte is found correct
// - ownership change asserts Alert# on both buses
// - rectifier-raised status cleared only by controlling master's clear-faults or by a restart from latch-off
// - power-up overload held in constant current up to 20 s after a delayed start (bus18 set at insertion)
// - in limit above 36 V keep blinking output LED, below it hiccup
// - any restart from latch-off keeps output off at least 2 s
// - successful restart from latch-off clears alarms and sets restart-succeeded flag
// - overvoltage: three 1 s retries in 1 min window, then latch off
// - overcurrent and overtemp auto-restart unless configured to latch
// - status settles, then Alert# and held contents until clear; adds allowed
// - external faults raise no fault LED, fault pin or bus alarm
// - state-change alert at power-up and on any change of a status bit outside EXT_MASK
// - insertion keeps output off; bus voltage decides turn-on style
// - setpoint mismatch waits for voltage command or later agreement
// - ownership byte readable by either master at any time
module fault_supervisor #(
  parameter [16:0] TICK_CYC = `TICK_CYC
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [1:0]  cmd_stb_i,
  input  wire [1:0]  cmd_rd_i,
  input  wire [1:0]  cmd_pec_ok_i,
  input  wire [15:0] cmd_code_i,
  input  wire [1:0]  wr_busy_i,
  input  wire        oper_on_i,
  input  wire        vout_cmd_i,
  input  wire        oc_latch_i,
  input  wire        ot_latch_i,
  input  wire [15:0] rect_status_i,
  input  wire        en_pin_i,
  input  wire        ac_ok_i,
  input  wire        ovld_i,
  input  wire        ov_i,
  input  wire        oc_i,
  input  wire        ot_i,
  input  wire        int_flt_i,
  input  wire        v36_i,
  input  wire        bus18_i,
  input  wire        vmatch_i,
  output wire [7:0]  own_status_o,
  output wire [1:0]  cmd_ack_o,
  output wire [1:0]  cmd_nak_o,
  output wire [1:0]  alert_do_o,
  output wire [1:0]  alert_oe_n_o,
  output wire [15:0] held_status_o,
  output wire        out_en_o,
  output wire        cc_hold_o,
  output wire        out_led_o,
  output wire        fault_led_o,
  output wire        fault_pin_o,
  output wire        restart_ok_o,
  output wire        alarm_clr_o
);
  localparam [5:0] S_INS   = 6'h01;
  localparam [5:0] S_WAIT  = 6'h02;
  localparam [5:0] S_ON    = 6'h04;
  localparam [5:0] S_OFF   = 6'h08;
  localparam [5:0] S_RETRY = 6'h10;
  localparam [5:0] S_LATCH = 6'h20;

  wire [9:0] pins;
  wire       s_en, s_ac, s_ovld, s_ov, s_oc;
  wire       s_ot, s_int, s_v36, s_bus18, s_vmatch;

  sync2 #(.W(10)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({en_pin_i, ac_ok_i, ovld_i, ov_i, oc_i, ot_i,
             int_flt_i, v36_i, bus18_i, vmatch_i}),
    .q_o   (pins)
  );
  assign {s_en, s_ac, s_ovld, s_ov, s_oc, s_ot,
          s_int, s_v36, s_bus18, s_vmatch} = pins;

  // millisecond tick
  reg [16:0] tick_cnt_ff;
  reg        tick_ff;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_ff <= 17'h00000;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == TICK_CYC - 17'h00001) begin
      tick_cnt_ff <= 17'h00000;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 17'h00001;
      tick_ff     <= 1'b0;
    end
  end
  // bus ownership
  reg [7:0]  own_ff;
  reg [1:0]  ack_ff, nak_ff, rect_alt_ff, alert_oe_n_ff, alert_do_ff;
  reg        owner_clr_ff;
  reg [7:0]  code, nxt_own;
  reg [1:0]  nxt_ack, nxt_nak, nxt_ralt_clr;
  reg        nxt_owner_clr;
  integer    i;

  always @* begin
    nxt_own       = own_ff;
    nxt_ack       = 2'h0;
    nxt_nak       = 2'h0;
    nxt_ralt_clr  = 2'h0;
    nxt_owner_clr = 1'b0;
    code          = 8'h00;
    for (i = 0; i < 2; i = i + 1) begin
      code = cmd_code_i[8*i +: 8];
      if (cmd_stb_i[i]) begin
        if (cmd_rd_i[i]) begin
          nxt_ack[i] = 1'b1;
        end else if (!cmd_pec_ok_i[i]) begin
          nxt_nak[i] = 1'b1;
          nxt_own[4*i + `F_ERR] = 1'b1;
        end else if (own_ff[4*i + `F_CTL]) begin
          nxt_ack[i] = 1'b1;
          if (code == `CMD_CLRF) begin
            nxt_own[4*i + `F_ALEN] = 1'b0;
            nxt_own[4*i + `F_ERR]  = 1'b0;
            nxt_ralt_clr[i]        = 1'b1;
            nxt_owner_clr          = 1'b1;
          end
        end else if (code == `CMD_CLAIM) begin
          nxt_ack[i] = 1'b1;
          nxt_own[4*i + `F_REQ] = 1'b1;
        end else if (code == `CMD_CLRF) begin
          nxt_ack[i] = 1'b1;
          nxt_own[4*i + `F_ALEN] = 1'b0;
          nxt_own[4*i + `F_ERR]  = 1'b0;
          nxt_ralt_clr[i]        = 1'b1;
        end else begin
          nxt_nak[i] = 1'b1;
          nxt_own[4*i + `F_ERR] = 1'b1;
        end
      end
    end
    // hand-over last so the alert set beats a same-cycle clear
    for (i = 0; i < 2; i = i + 1) begin
      if (own_ff[4*i + `F_REQ] && !own_ff[4*i + `F_CTL] &&
          !wr_busy_i[1-i]) begin
        nxt_own[4*i + `F_CTL]     = 1'b1;
        nxt_own[4*i + `F_REQ]     = 1'b0;
        nxt_own[4*(1-i) + `F_CTL] = 1'b0;
        nxt_own[4*(1-i) + `F_REQ] = 1'b0;
        nxt_own[`F_ALEN]          = 1'b1;
        nxt_own[4 + `F_ALEN]      = 1'b1;
      end
    end
  end

  // only bias loss (rst_i) restores the default byte
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      own_ff        <= `OWN_RST;
      ack_ff        <= 2'h0;
      nak_ff        <= 2'h0;
      owner_clr_ff  <= 1'b0;
      alert_oe_n_ff <= 2'h3;
      alert_do_ff   <= 2'h0;
    end else begin
      own_ff        <= nxt_own;
      ack_ff        <= nxt_ack;
      nak_ff        <= nxt_nak;
      owner_clr_ff  <= nxt_owner_clr;
      alert_oe_n_ff <= ~({own_ff[4 + `F_ALEN], own_ff[`F_ALEN]} |
                         rect_alt_ff);
      alert_do_ff   <= 2'h0;
    end
  end
  // status notification
  reg [15:0] prev_ff, held_ff, settle_ff;
  reg        pend_ff, cint_ff, aclr_ff;
  wire [15:0] diff = rect_status_i ^ prev_ff;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_ff     <= 16'h0000;
      held_ff     <= 16'h0000;
      settle_ff   <= 16'h0000;
      pend_ff     <= 1'b1;
      cint_ff     <= 1'b1;
      rect_alt_ff <= 2'h0;
    end else begin
      prev_ff    <= rect_status_i;
      if (owner_clr_ff || aclr_ff)
        held_ff <= 16'h0000;
      rect_alt_ff <= rect_alt_ff & ~nxt_ralt_clr;
      if (diff != 16'h0000) begin
        pend_ff   <= 1'b1;
        settle_ff <= 16'h0000;
        if ((diff & ~`EXT_MASK) != 16'h0000)
          cint_ff <= 1'b1;
      end else if (pend_ff) begin
        if (settle_ff >= `SETTLE_MS) begin
          pend_ff    <= 1'b0;
          cint_ff    <= 1'b0;
          held_ff    <= held_ff | rect_status_i;
          if (cint_ff)
            rect_alt_ff <= 2'h3;
        end else if (tick_ff) begin
          settle_ff <= settle_ff + 16'h0001;
        end
      end
    end
  end
  // power state
  reg [5:0]  state_ff;
  reg [15:0] tmr_ff, win_ff;
  reg [1:0]  ov_cnt_ff;
  reg        dly_ff, seen_off_ff, from_latch_ff, rok_ff;
  reg        out_en_ff, cc_ff, oled_ff, fled_ff;
  reg [7:0]  blk_ff;
  wire       run_ok = s_en & s_ac & oper_on_i;
  wire       cc_win = dly_ff & (tmr_ff < `CC_HOLD_MS);
  wire       limit_trip = s_oc | (s_ovld & !cc_win & !s_v36);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff      <= S_INS;
      tmr_ff        <= 16'h0000;
      win_ff        <= 16'h0000;
      ov_cnt_ff     <= 2'h0;
      dly_ff        <= 1'b0;
      seen_off_ff   <= 1'b0;
      from_latch_ff <= 1'b0;
      rok_ff        <= 1'b0;
      aclr_ff       <= 1'b0;
    end else begin
      aclr_ff <= 1'b0;
      if (owner_clr_ff)
        rok_ff <= 1'b0;
      if (tick_ff && tmr_ff != 16'hFFFF)
        tmr_ff <= tmr_ff + 16'h0001;
      if (ov_cnt_ff != 2'h0 && tick_ff) begin
        if (win_ff >= `OV_WIN_MS - 16'h0001) begin
          win_ff    <= 16'h0000;
          ov_cnt_ff <= 2'h0;
        end else begin
          win_ff <= win_ff + 16'h0001;
        end
      end
      case (state_ff)
        S_INS: begin
          tmr_ff <= 16'h0000;
          // wait a tick so the synchronised pins are real, not reset zeros
          if (tick_ff && !s_bus18) begin
            state_ff <= S_ON;
            dly_ff   <= 1'b0;
          end else if (tick_ff && s_vmatch) begin
            state_ff <= S_ON;
            dly_ff   <= 1'b1;
          end else if (tick_ff) begin
            state_ff <= S_WAIT;
          end
        end
        S_WAIT: begin
          tmr_ff <= 16'h0000;
          if (vout_cmd_i || s_vmatch) begin
            state_ff <= S_ON;
            dly_ff   <= 1'b1;
          end
        end
        S_ON: begin
          if (!run_ok) begin
            state_ff <= S_OFF;
            tmr_ff   <= 16'h0000;
          end else if (s_ov) begin
            tmr_ff <= 16'h0000;
            if (ov_cnt_ff == `OV_MAX) begin
              state_ff <= S_LATCH;
            end else begin
              state_ff  <= S_RETRY;
              ov_cnt_ff <= ov_cnt_ff + 2'h1;
            end
          end else if (s_ot) begin
            state_ff <= ot_latch_i ? S_LATCH : S_OFF;
            tmr_ff   <= 16'h0000;
          end else if (limit_trip) begin
            // below 36 V the restart path is the hiccup
            state_ff <= oc_latch_i ? S_LATCH : S_OFF;
            tmr_ff   <= 16'h0000;
          end
        end
        S_RETRY: begin
          if (tmr_ff >= `OV_RETRY_MS) begin
            state_ff <= S_ON;
            tmr_ff   <= 16'h0000;
            dly_ff   <= 1'b0;
          end
        end
        S_OFF: begin
          if (tmr_ff >= `OFF_MIN_MS && run_ok) begin
            state_ff      <= S_ON;
            tmr_ff        <= 16'h0000;
            dly_ff        <= 1'b0;
            from_latch_ff <= 1'b0;
            if (from_latch_ff) begin
              rok_ff  <= 1'b1;
              aclr_ff <= 1'b1;
            end
          end
        end
        S_LATCH: begin
          tmr_ff <= 16'h0000;
          if (!run_ok)
            seen_off_ff <= 1'b1;
          if (seen_off_ff && run_ok) begin
            state_ff      <= S_OFF;
            seen_off_ff   <= 1'b0;
            from_latch_ff <= 1'b1;
            ov_cnt_ff     <= 2'h0;
            win_ff        <= 16'h0000;
          end
        end
        default: begin
          state_ff <= S_INS;
        end
      endcase
    end
  end

  // indicators and power outputs
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_en_ff <= 1'b0;
      cc_ff     <= 1'b0;
      oled_ff   <= 1'b0;
      fled_ff   <= 1'b0;
      blk_ff    <= 8'h00;
    end else begin
      if (tick_ff)
        blk_ff <= blk_ff + 8'h01;
      out_en_ff <= (state_ff == S_ON) & run_ok;
      cc_ff     <= (state_ff == S_ON) & s_ovld & cc_win;
      // limit above 36 V keeps running with a blinking LED
      oled_ff   <= (state_ff == S_ON) &
                   (!s_ovld | (s_v36 & blk_ff[7]));
      fled_ff   <= s_int | s_ov | s_ot;
    end
  end

  assign own_status_o  = own_ff;
  assign cmd_ack_o     = ack_ff;
  assign cmd_nak_o     = nak_ff;
  assign alert_do_o    = alert_do_ff;
  assign alert_oe_n_o  = alert_oe_n_ff;
  assign held_status_o = held_ff;
  assign out_en_o      = out_en_ff;
  assign cc_hold_o     = cc_ff;
  assign out_led_o     = oled_ff;
  assign fault_led_o   = fled_ff;
  assign fault_pin_o   = fled_ff;
  assign restart_ok_o  = rok_ff;
  assign alarm_clr_o   = aclr_ff;
endmodule

// ==== bench/sup_checker_assertions.sv ====
`timescale 1ns/1ps
module sup_checker (
  input wire        clk_i,
  input wire        rst_i,
  input wire [1:0]  cmd_stb_i,
  input wire [1:0]  cmd_rd_i,
  input wire [1:0]  cmd_pec_ok_i,
  input wire [15:0] cmd_code_i,
  input wire [1:0]  wr_busy_i,
  input wire [7:0]  own_status_o,
  input wire [1:0]  cmd_ack_o,
  input wire [1:0]  cmd_nak_o,
  input wire [1:0]  alert_do_o,
  input wire [1:0]  alert_oe_n_o,
  input wire [15:0] held_status_o,
  input wire        restart_ok_o,
  input wire        alarm_clr_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire [1:0] rd_req = cmd_stb_i & cmd_rd_i;
  wire       wr1    = cmd_stb_i[1] & ~cmd_rd_i[1] & own_status_o[0];
  wire [7:0] code1  = cmd_code_i[15:8];
  property p_answer;
    cmd_stb_i[0] |=> cmd_ack_o[0] ^ cmd_nak_o[0];
  endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_reads;
    |rd_req |=> (cmd_ack_o & $past(rd_req)) == $past(rd_req);
  endproperty
  a_reads: assert property (p_reads) else $error("read not acked");
  property p_refuse;
    wr1 && code1 != 8'hD8 && code1 != 8'h03 |=> cmd_nak_o[1];
  endproperty
  a_refuse: assert property (p_refuse) else $error("foreign write taken");
  property p_pec;
    wr1 && code1 == 8'hD8 && !cmd_pec_ok_i[1] |=> cmd_nak_o[1] ##1 own_status_o[0];
  endproperty
  a_pec: assert property (p_pec) else $error("bad check byte obeyed");
  property p_idle;
    own_status_o[5] && own_status_o[0] && wr_busy_i[0] |=> own_status_o[0];
  endproperty
  a_idle: assert property (p_idle) else $error("moved during write");
  property p_alert;
    $rose(own_status_o[4]) |-> ##[0:2] alert_oe_n_o == 2'h0;
  endproperty
  a_alert: assert property (p_alert) else $error("no alert on change");
  property p_excl;
    own_status_o[0] ^ own_status_o[4];
  endproperty
  a_excl: assert property (p_excl) else $error("owner not unique");
  property p_pin;
    alert_do_o == 2'h0;
  endproperty
  a_pin: assert property (p_pin) else $error("alert data driven high");
  property p_clr;
    cmd_stb_i[0] && !cmd_rd_i[0] && cmd_code_i[7:0] == 8'h03
      && own_status_o[0] |=> ##1 held_status_o == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("held not cleared");
  property p_restart;
    alarm_clr_o |-> ##[0:1] restart_ok_o;
  endproperty
  a_restart: assert property (p_restart) else $error("restart flag lost");
  property p_boot;
    $fell(rst_i) |-> own_status_o == 8'h01;
  endproperty
  a_boot: assert property (p_boot) else $error("wrong default owner");
  c_claim: cover property ($rose(own_status_o[4]));
  c_both: cover property (rd_req == 2'h3);
  c_restart: cover property ($rose(restart_ok_o));
endmodule
bind fault_supervisor sup_checker sup_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cmd_stb_i(cmd_stb_i), .cmd_rd_i(cmd_rd_i),
  .cmd_pec_ok_i(cmd_pec_ok_i), .cmd_code_i(cmd_code_i),
  .wr_busy_i(wr_busy_i), .own_status_o(own_status_o),
  .cmd_ack_o(cmd_ack_o), .cmd_nak_o(cmd_nak_o), .alert_do_o(alert_do_o),
  .alert_oe_n_o(alert_oe_n_o), .held_status_o(held_status_o),
  .restart_ok_o(restart_ok_o), .alarm_clr_o(alarm_clr_o)
);

// ==== bench/ctl_model.sv ====
`timescale 1ns/1ps
module ctl_model (
  input  wire        clk_i,
  output reg  [1:0]  cmd_stb_o,
  output reg  [1:0]  cmd_rd_o,
  output reg  [1:0]  cmd_pec_ok_o,
  output reg  [15:0] cmd_code_o,
  output reg  [1:0]  wr_busy_o
);
  initial begin
    cmd_stb_o = 2'h0;
    cmd_rd_o = 2'h0;
    cmd_pec_ok_o = 2'h0;
    cmd_code_o = 16'hA5C3;
    wr_busy_o = 2'h0;
  end
  // idle code keeps shifting so decoding outside a strobe shows up
  always @(posedge clk_i) begin
    if (cmd_stb_o == 2'h0) cmd_code_o <= {cmd_code_o[14:0], ~cmd_code_o[15]};
  end
  // one transfer per selected bus, ended with stop in a single strobe
  task send(input [1:0] m, input [15:0] c, input r, input p);
    @(negedge clk_i);
    cmd_code_o = c;
    cmd_rd_o = {2{r}};
    cmd_pec_ok_o = {2{p}};
    cmd_stb_o = m;
    @(negedge clk_i);
    cmd_stb_o = 2'h0;
  endtask
  task busy(input [1:0] b);
    @(negedge clk_i);
    wr_busy_o = b;
  endtask
endmodule

// ==== bench/tb_fault_supervisor.sv ====
`timescale 1ns/1ps
module tb_fault_supervisor;
  reg         clk_i, rst_i, en_pin_i, ac_ok_i, oper_on_i, oc_latch_i;
  reg         oc_i, ovld_i, v36_i, bus18_i, vmatch_i, vout_cmd_i, ov_i;
  reg         int_flt_i;
  reg  [15:0] rect_status_i;
  wire [1:0]  stb, rd, pec, wbusy, cmd_ack_o, cmd_nak_o, ado, alert_oe_n_o;
  wire [15:0] code, held_status_o;
  wire [7:0]  own_status_o;
  wire        out_en_o, cc_hold_o, led, fault_led_o, fault_pin_o;
  wire        restart_ok_o, aclr;
  integer     n_fail, checks_done, seed, owner, i, n;
  reg  [1:0]  err, alen;
  ctl_model ctl_model_inst (.clk_i(clk_i), .cmd_stb_o(stb), .cmd_rd_o(rd),
    .cmd_pec_ok_o(pec), .cmd_code_o(code), .wr_busy_o(wbusy));
  fault_supervisor #(.TICK_CYC(17'd10)) fault_supervisor_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cmd_stb_i(stb), .cmd_rd_i(rd),
    .cmd_pec_ok_i(pec), .cmd_code_i(code), .wr_busy_i(wbusy),
    .oper_on_i(oper_on_i), .vout_cmd_i(vout_cmd_i), .oc_latch_i(oc_latch_i),
    .ot_latch_i(1'b0), .rect_status_i(rect_status_i), .en_pin_i(en_pin_i),
    .ac_ok_i(ac_ok_i), .ovld_i(ovld_i), .ov_i(ov_i), .oc_i(oc_i),
    .ot_i(1'b0), .int_flt_i(int_flt_i), .v36_i(v36_i), .bus18_i(bus18_i),
    .vmatch_i(vmatch_i), .own_status_o(own_status_o), .cmd_ack_o(cmd_ack_o),
    .cmd_nak_o(cmd_nak_o), .alert_do_o(ado), .alert_oe_n_o(alert_oe_n_o),
    .held_status_o(held_status_o), .out_en_o(out_en_o), .cc_hold_o(cc_hold_o),
    .out_led_o(led), .fault_led_o(fault_led_o), .fault_pin_o(fault_pin_o),
    .restart_ok_o(restart_ok_o), .alarm_clr_o(aclr));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function [7:0] expo(input integer o);
    expo = {err[1], alen[1], 1'b0, o == 1, err[0], alen[0], 1'b0, o == 0};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmd(input [1:0] m, input [15:0] c, input r, input p, input [3:0] e);
    ctl_model_inst.send(m, c, r, p);
    chk({cmd_nak_o, cmd_ack_o}, e);
  endtask
  task wait_n(input integer k);
    repeat (k) @(negedge clk_i);
  endtask
  task results;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #600000;
    n_fail = n_fail + 1;
    results;
  end
  initial begin
    seed = 53;
    n_fail = 0;
    checks_done = 0;
    {rst_i, en_pin_i, ac_ok_i, oper_on_i, v36_i} = 5'h1F;
    {oc_latch_i, oc_i, ovld_i, bus18_i, vout_cmd_i, ov_i, int_flt_i} = 7'h00;
    vmatch_i = $random(seed);
    rect_status_i = 16'h0000;
    owner = 0;
    err = 2'h0;
    alen = 2'h0;
    wait_n(10);
    rst_i = 1'b0;
    chk(own_status_o, expo(owner));
    chk(alert_oe_n_o, 2'h3);
    n = 0;
    while (alert_oe_n_o !== 2'h0 && n < 400) begin
      wait_n(1);
      n = n + 1;
    end
    chk(alert_oe_n_o, 2'h0);
    chk({out_en_o, cc_hold_o, led}, 3'h5);
    cmd(2'h1, 16'h0003, 1'b0, 1'b1, 4'h1);
    cmd(2'h2, 16'h0300, 1'b0, 1'b1, 4'h2);
    wait_n(3);
    chk(alert_oe_n_o, 2'h3);
    chk(own_status_o, expo(owner));
    for (i = 0; i < 9; i = i + 1) begin
      cmd(i % 3 + 1, $random(seed), 1'b1, 1'b1, i % 3 + 1);
    end
    cmd(2'h2, 16'h0100, 1'b0, 1'b1, 4'h8);
    err[1] = 1'b1;
    wait_n(1);
    chk(own_status_o, expo(owner));
    cmd(2'h2, 16'hD800, 1'b0, 1'b0, 4'h8);
    wait_n(2);
    chk(own_status_o, expo(owner));
    cmd(2'h2, 16'h0300, 1'b0, 1'b1, 4'h2);
    err[1] = 1'b0;
    ctl_model_inst.busy(2'h1);
    cmd(2'h2, 16'hD800, 1'b0, 1'b1, 4'h2);
    wait_n(5);
    chk(own_status_o[5:4], 2'h2);
    ctl_model_inst.busy(2'h0);
    wait_n(4);
    owner = 1;
    alen = 2'h3;
    chk(own_status_o, expo(owner));
    chk({ado, alert_oe_n_o}, 4'h0);
    cmd(2'h1, 16'h0003, 1'b0, 1'b1, 4'h1);
    cmd(2'h2, 16'h0300, 1'b0, 1'b1, 4'h2);
    alen = 2'h0;
    wait_n(3);
    chk(alert_oe_n_o, 2'h3);
    chk(own_status_o, expo(owner));
    rect_status_i = 16'h0010;
    wait_n(200);
    chk(held_status_o, 16'h0010);
    chk(alert_oe_n_o, 2'h0);
    cmd(2'h1, 16'h0003, 1'b0, 1'b1, 4'h1);
    wait_n(2);
    chk({held_status_o, alert_oe_n_o}, {16'h0010, 2'h1});
    cmd(2'h2, 16'h0300, 1'b0, 1'b1, 4'h2);
    wait_n(2);
    chk(held_status_o, 16'h0000);
    rect_status_i = 16'h0011;
    wait_n(200);
    chk(alert_oe_n_o, 2'h3);
    ovld_i = 1'b1;
    wait_n(500);
    chk({out_en_o, fault_pin_o, fault_led_o}, 3'h4);
    n = 0;
    for (i = 0; i < 2600; i = i + 1) begin
      wait_n(1);
      n = n + led;
    end
    chk(n > 0 && n < 2600, 1'b1);
    ovld_i = 1'b0;
    oc_latch_i = 1'b1;
    oc_i = 1'b1;
    wait_n(100);
    oc_i = 1'b0;
    wait_n(500);
    chk(out_en_o, 1'b0);
    en_pin_i = 1'b0;
    wait_n(50);
    en_pin_i = 1'b1;
    n = 0;
    while (out_en_o !== 1'b1 && n < 30000) begin
      wait_n(1);
      n = n + 1;
    end
    // tick phase may trim the first millisecond by a few clocks
    chk(n >= 19990, 1'b1);
    chk({out_en_o, restart_ok_o}, 2'h3);
    chk(held_status_o, 16'h0000);
    int_flt_i = 1'b1;
    wait_n(4);
    chk({fault_pin_o, fault_led_o}, 2'h3);
    int_flt_i = 1'b0;
    ov_i = 1'b1;
    wait_n(4);
    ov_i = 1'b0;
    chk(out_en_o, 1'b0);
    n = 0;
    while (out_en_o !== 1'b1 && n < 12000) begin
      wait_n(1);
      n = n + 1;
    end
    // one retry delay of 1000 ticks, give or take the tick phase
    chk(n >= 9980 && n <= 10010, 1'b1);
    {bus18_i, vmatch_i, rst_i} = 3'h5;
    wait_n(10);
    rst_i = 1'b0;
    chk({own_status_o, restart_ok_o}, 9'h002);
    wait_n(60);
    chk({out_en_o, cc_hold_o}, 2'h0);
    {vout_cmd_i, ovld_i} = 2'h3;
    wait_n(1);
    vout_cmd_i = 1'b0;
    wait_n(4);
    chk({out_en_o, cc_hold_o}, 2'h3);
    results;
  end
endmodule
